/* logic/timer2_params.svh */
`ifndef TIMER2_PARAMS_SVH
`define TIMER2_PARAMS_SVH

`define ADDR_CTRL_LOW      8'hC0
`define ADDR_CTRL_HIGH     8'hC1
`define ADDR_INIT_LOW      8'hC2
`define ADDR_INIT_HIGH     8'hC3
`define ADDR_PERIOD_LOW    8'hC4
`define ADDR_PERIOD_HIGH   8'hC5
`define ADDR_DUTY_LOW      8'hC6
`define ADDR_DUTY_HIGH     8'hC7

`define RST_BYTE_ZERO      8'h00
`define RST_BYTE_ONES      8'hFF

`define CL_MODE_LSB        0
`define CL_SRC_LSB         2
`define CL_PSC_LSB         5
`define CH_EDGE_LSB        0
`define CH_CSRC_LSB        2
`define CH_CAPTURE_INTERRUPT_ENABLE_BIT      4
`define CH_CNT_IE_BIT      5
`define CH_CAP_PND_BIT     6
`define CH_CNT_PND_BIT     7

`define EDGE_RISE          2'h0
`define EDGE_FALL          2'h1
`define CSRC_CMP0          2'h2
`define CSRC_CMP1          2'h3

`define SRC_PIN_RISE       3'h0
`define SRC_PIN_FALL       3'h1
`define SRC_FAST_OSC       3'h2
`define SRC_SLOW_OSC       3'h3
`define SRC_CRYSTAL        3'h4

`endif

/* logic/timer2_pkg.sv */
`default_nettype none
package timer2_pkg;
  typedef enum logic [1:0] {
    MODE_OFF     = 2'b00,
    MODE_COUNTER = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_CAPTURE = 2'b11
  } mode_e;
endpackage
`default_nettype wire

/* logic/edge_prescaler.sv */
`default_nettype none
`include "timer2_params.svh"
// count source selection, edge detect and power-of-two prescaler
module edge_prescaler (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_enable,
  input  wire logic [2:0] i_source_select,
  input  wire logic [2:0] i_prescaler_select,
  input  wire logic       i_pin,
  input  wire logic       i_fast_osc,
  input  wire logic       i_slow_osc,
  input  wire logic       i_crystal,
  output logic            o_tick
);
  logic [2:0] prev_q;
  logic       pin_prev_q;
  logic [6:0] div_q;
  logic       event_raw;
  logic       div_hit;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      prev_q     <= 3'h0;
      pin_prev_q <= 1'b0;
    end else begin
      prev_q     <= {i_crystal, i_slow_osc, i_fast_osc};
      pin_prev_q <= i_pin;
    end
  end

  // divided-by-two sources count on both edges
  always_comb begin
    case (i_source_select) // [R18]
      `SRC_PIN_RISE: event_raw = i_pin & ~pin_prev_q;
      `SRC_PIN_FALL: event_raw = ~i_pin & pin_prev_q;
      `SRC_FAST_OSC: event_raw = i_fast_osc ^ prev_q[0];
      `SRC_SLOW_OSC: event_raw = i_slow_osc ^ prev_q[1];
      `SRC_CRYSTAL:  event_raw = i_crystal ^ prev_q[2];
      default:       event_raw = 1'b1; // [R18]
    endcase
  end

  assign div_hit = ((div_q & ((7'h01 << i_prescaler_select) - 7'h01)) == ((7'h01 << i_prescaler_select) - 7'h01));

  always_ff @(posedge i_clock) begin
    if (i_rst || !i_enable) begin
      div_q  <= 7'h00;
      o_tick <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (event_raw) begin
        if (div_hit) begin
          div_q  <= 7'h00;
          o_tick <= 1'b1; // [R19]
        end else begin
          div_q <= div_q + 7'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* logic/basic_timer.sv */
`default_nettype none
`include "timer2_params.svh"
// How it works
// R01: capture irq enable at high control bit 4
// R02: capture source: pin, comparator 0, comparator 1
// R03: capture edge: rising, falling, both edges
// R04: initial count bytes, reset zero, start value
// R05: period bytes reset to all ones
// R06: pwm duty from duty/capture pair
// R07: capture latches counter into duty/capture pair
// R08: mode 01 counter, 10 pwm, 11 capture
// R09: software writes mode field last
// R10: count event sets count pending, irq if enabled
// R11: capture sets capture pending, irq if enabled
// R12: software clears pending flags before configuring
// R13: count irq enable at high control bit 5
// R14: source select 4:2, prescaler 7:5 low control
// R15: software zeroes duty/capture pair before capture
// R16: edge field ignored for comparator sources
// R17: software reads captured value from pair
// R18: count source codes pin, oscillators, system clock
// R19: prescaler divides by two to the power
// R20: pending flags clear on write one
// R21: mode zero stops counting, capture and pwm
// R22: count from initial, wrap at period, flag
// R23: pwm active below duty until period wrap
module basic_timer (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_write,
  input  wire logic       i_read,
  input  wire logic       i_timer_input_pin,
  input  wire logic       i_comparator0,
  input  wire logic       i_comparator1,
  input  wire logic       i_fast_osc_div2,
  input  wire logic       i_slow_osc_div2,
  input  wire logic       i_crystal_div2,
  output logic [7:0]      o_rdata,
  output logic            o_pwm,
  output logic            o_count_irq,
  output logic            o_capture_irq
);
  logic [7:0]  low_control_register_q;
  logic        count_pending_flag_q;
  logic        capture_pending_flag_q;
  logic        count_irq_enable_q;
  logic        capture_irq_enable_q;
  logic [1:0]  capture_source_q;
  logic [1:0]  capture_edge_select_q;
  logic [7:0]  initial_count_low_q;
  logic [7:0]  initial_count_high_q;
  logic [7:0]  period_value_low_q;
  logic [7:0]  period_value_high_q;
  logic [7:0]  duty_capture_low_q;
  logic [7:0]  duty_capture_high_q;
  logic [15:0] count_q;
  logic        cap_pin_prev_q;
  logic        cmp0_prev_q;
  logic        cmp1_prev_q;
  logic        running_q;

  timer2_pkg::mode_e mode;
  logic [2:0]  source_select;
  logic [2:0]  prescaler_select;
  logic [15:0] period_value;
  logic [15:0] initial_count;
  logic [15:0] duty_value;
  logic        tick;
  logic        wrap;
  logic        capture_event;
  logic        pin_rise;
  logic        pin_fall;
  logic        wr_ctrl_high;

  assign mode = timer2_pkg::mode_e'(low_control_register_q[`CL_MODE_LSB +: 2]);                    // [R08]
  assign source_select    = low_control_register_q[`CL_SRC_LSB +: 3];                              // [R14]
  assign prescaler_select = low_control_register_q[`CL_PSC_LSB +: 3];                              // [R14]
  assign period_value  = {period_value_high_q, period_value_low_q};
  assign initial_count = {initial_count_high_q, initial_count_low_q};
  assign duty_value    = {duty_capture_high_q, duty_capture_low_q};
  assign wr_ctrl_high  = i_write && (i_addr == `ADDR_CTRL_HIGH);

  edge_prescaler u_prescaler (
    .i_clock            (i_clock),
    .i_rst              (i_rst),
    .i_enable           (mode != timer2_pkg::MODE_OFF),
    .i_source_select    (source_select),
    .i_prescaler_select (prescaler_select),
    .i_pin              (i_timer_input_pin),
    .i_fast_osc         (i_fast_osc_div2),
    .i_slow_osc         (i_slow_osc_div2),
    .i_crystal          (i_crystal_div2),
    .o_tick             (tick)
  );                                                                                               // [R18] [R19]

  assign wrap = tick && (count_q == period_value);                                                 // [R22]

  // capture event detection
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cap_pin_prev_q <= 1'b0;
      cmp0_prev_q    <= 1'b0;
      cmp1_prev_q    <= 1'b0;
    end else begin
      cap_pin_prev_q <= i_timer_input_pin;
      cmp0_prev_q    <= i_comparator0;
      cmp1_prev_q    <= i_comparator1;
    end
  end

  assign pin_rise = i_timer_input_pin & ~cap_pin_prev_q;
  assign pin_fall = ~i_timer_input_pin & cap_pin_prev_q;

  always_comb begin
    case (capture_source_q)
      `CSRC_CMP0: capture_event = i_comparator0 & ~cmp0_prev_q;                                    // [R02] [R16]
      `CSRC_CMP1: capture_event = i_comparator1 & ~cmp1_prev_q;                                    // [R02] [R16]
      default: begin
        case (capture_edge_select_q)
          `EDGE_RISE: capture_event = pin_rise;                                                     // [R03]
          `EDGE_FALL: capture_event = pin_fall;                                                     // [R03]
          default:    capture_event = pin_rise | pin_fall;                                          // [R03]
        endcase
      end
    endcase
  end

  // low control register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      low_control_register_q <= `RST_BYTE_ZERO;
    end else if (i_write && i_addr == `ADDR_CTRL_LOW) begin
      low_control_register_q <= i_wdata;
    end
  end

  // high control register enables and selectors
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count_irq_enable_q    <= 1'b0;
      capture_irq_enable_q  <= 1'b0;
      capture_source_q      <= 2'h0;
      capture_edge_select_q <= 2'h0;
    end else if (wr_ctrl_high) begin
      count_irq_enable_q    <= i_wdata[`CH_CNT_IE_BIT];                                            // [R13]
      capture_irq_enable_q  <= i_wdata[`CH_CAPTURE_INTERRUPT_ENABLE_BIT];                                            // [R01]
      capture_source_q      <= i_wdata[`CH_CSRC_LSB +: 2];                                         // [R02]
      capture_edge_select_q <= i_wdata[`CH_EDGE_LSB +: 2];                                         // [R03]
    end
  end

  // pending flags: write one clears, a same-cycle event wins
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count_pending_flag_q   <= 1'b0;
      capture_pending_flag_q <= 1'b0;
    end else begin
      if (mode == timer2_pkg::MODE_COUNTER && wrap) begin
        count_pending_flag_q <= 1'b1;                                                              // [R10] [R22]
      end else if (wr_ctrl_high && i_wdata[`CH_CNT_PND_BIT]) begin
        count_pending_flag_q <= 1'b0;                                                              // [R20]
      end
      if (mode == timer2_pkg::MODE_CAPTURE && capture_event) begin
        capture_pending_flag_q <= 1'b1;                                                            // [R11]
      end else if (wr_ctrl_high && i_wdata[`CH_CAP_PND_BIT]) begin
        capture_pending_flag_q <= 1'b0;                                                            // [R20]
      end
    end
  end

  // initial count and period bytes
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      initial_count_low_q  <= `RST_BYTE_ZERO;                                                       // [R04]
      initial_count_high_q <= `RST_BYTE_ZERO;                                                       // [R04]
      period_value_low_q   <= `RST_BYTE_ONES;                                                       // [R05]
      period_value_high_q  <= `RST_BYTE_ONES;                                                       // [R05]
    end else if (i_write) begin
      case (i_addr)
        `ADDR_INIT_LOW:    initial_count_low_q  <= i_wdata;
        `ADDR_INIT_HIGH:   initial_count_high_q <= i_wdata;
        `ADDR_PERIOD_LOW:  period_value_low_q   <= i_wdata;
        `ADDR_PERIOD_HIGH: period_value_high_q  <= i_wdata;
        default: ;
      endcase
    end
  end

  // duty/capture pair; capture overrides a same-cycle write
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      duty_capture_low_q  <= `RST_BYTE_ZERO;
      duty_capture_high_q <= `RST_BYTE_ZERO;
    end else if (mode == timer2_pkg::MODE_CAPTURE && capture_event) begin
      duty_capture_low_q  <= count_q[7:0];                                                          // [R07]
      duty_capture_high_q <= count_q[15:8];                                                         // [R07]
    end else if (i_write && i_addr == `ADDR_DUTY_LOW) begin
      duty_capture_low_q <= i_wdata;
    end else if (i_write && i_addr == `ADDR_DUTY_HIGH) begin
      duty_capture_high_q <= i_wdata;
    end
  end

  // counter: loads initial value when mode leaves off
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count_q   <= 16'h0000;
      running_q <= 1'b0;
    end else if (mode == timer2_pkg::MODE_OFF) begin
      count_q   <= initial_count;                                                                   // [R21]
      running_q <= 1'b0;
    end else if (!running_q) begin
      count_q   <= initial_count;                                                                   // [R04]
      running_q <= 1'b1;
    end else if (wrap) begin
      count_q <= 16'h0000;                                                                          // [R22]
    end else if (tick) begin
      count_q <= count_q + 16'h0001;                                                                // [R22]
    end
  end

  // pwm output and interrupt requests
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pwm         <= 1'b0;
      o_count_irq   <= 1'b0;
      o_capture_irq <= 1'b0;
    end else begin
      o_pwm         <= (mode == timer2_pkg::MODE_PWM) && running_q && (count_q < duty_value);      // [R06] [R23] [R21]
      o_count_irq   <= count_pending_flag_q && count_irq_enable_q;                                  // [R10]
      o_capture_irq <= capture_pending_flag_q && capture_irq_enable_q;                              // [R11]
    end
  end

  // register read port
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_read) begin
      case (i_addr)
        `ADDR_CTRL_LOW:    o_rdata <= low_control_register_q;
        `ADDR_CTRL_HIGH:   o_rdata <= {count_pending_flag_q, capture_pending_flag_q, count_irq_enable_q,
                                       capture_irq_enable_q, capture_source_q, capture_edge_select_q};
        `ADDR_INIT_LOW:    o_rdata <= initial_count_low_q;
        `ADDR_INIT_HIGH:   o_rdata <= initial_count_high_q;
        `ADDR_PERIOD_LOW:  o_rdata <= period_value_low_q;
        `ADDR_PERIOD_HIGH: o_rdata <= period_value_high_q;
        `ADDR_DUTY_LOW:    o_rdata <= duty_capture_low_q;
        `ADDR_DUTY_HIGH:   o_rdata <= duty_capture_high_q;
        default:           o_rdata <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

/* testbench/basic_timer_sva.sv */
`default_nettype none
module basic_timer_sva (
  input wire logic       i_clock,
  input wire logic       i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_write,
  input wire logic       i_read,
  input wire logic [7:0] o_rdata,
  input wire logic       o_pwm,
  input wire logic       o_count_irq,
  input wire logic       o_capture_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic [7:0] byte_q [2:5];
  logic [7:0] exp_q;
  logic [1:0] mode_q;
  logic       chk_q, cnt_ie_q, capture_interrupt_enable_q;
  wire logic  in_rw;
  assign in_rw = i_addr >= 8'hC2 && i_addr <= 8'hC5;
  // mirror of plain bytes and control fields
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      byte_q <= '{8'h00, 8'h00, 8'hFF, 8'hFF};
      {cnt_ie_q, capture_interrupt_enable_q, mode_q, chk_q, exp_q} <= '0;
    end else begin
      if (i_write && in_rw) byte_q[i_addr[2:0]] <= i_wdata;
      if (i_write && i_addr == 8'hC1) {cnt_ie_q, capture_interrupt_enable_q} <= i_wdata[5:4];
      if (i_write && i_addr == 8'hC0) mode_q <= i_wdata[1:0];
      chk_q <= i_read && in_rw;
      exp_q <= in_rw ? byte_q[i_addr[2:0]] : 8'h00;
    end
  end
  a_byte_readback: assert property (chk_q |-> o_rdata == exp_q)
    else $error("byte readback wrong");
  a_unmapped_zero: assert property (i_read && (i_addr < 8'hC0 || i_addr > 8'hC7) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!i_read |=> $stable(o_rdata))
    else $error("read data moved");
  a_count_irq_gate: assert property (o_count_irq |-> $past(cnt_ie_q))
    else $error("count irq while disabled");
  a_capture_irq_gate: assert property (o_capture_irq |-> $past(capture_interrupt_enable_q))
    else $error("capture irq while disabled");
  a_pwm_mode_only: assert property (o_pwm |-> $past(mode_q) == timer2_pkg::MODE_PWM)
    else $error("pwm high outside pwm mode");
  a_count_w1c: assert property (i_write && i_addr == 8'hC1 && i_wdata[7] && mode_q == 2'b00 &&
    $past(mode_q) == 2'b00 |=> ##1 !o_count_irq)
    else $error("count pending not cleared");
  a_capture_w1c: assert property (i_write && i_addr == 8'hC1 && i_wdata[6] && mode_q == 2'b00 &&
    $past(mode_q) == 2'b00 |=> ##1 !o_capture_irq)
    else $error("capture pending not cleared");
endmodule
bind basic_timer basic_timer_sva chk (.i_clock, .i_rst, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata,
  .o_pwm, .o_count_irq, .o_capture_irq);
`default_nettype wire

/* testbench/far_side.sv */
`default_nettype none
module far_side (
  input  wire logic i_clock,
  output logic      o_pin,
  output logic      o_cmp0,
  output logic      o_cmp1,
  output logic      o_fast,
  output logic      o_slow,
  output logic      o_xtal
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  initial {o_pin, o_cmp0, o_cmp1, o_fast, o_slow, o_xtal} = '0;
  // halved oscillators, each at its own rate
  always @(posedge i_clock) begin
    #5;
    n++;
    if (n % 2 == 0) o_fast = ~o_fast;
    if (n % 5 == 0) o_slow = ~o_slow;
    if (n % 3 == 0) o_xtal = ~o_xtal;
  end
  task automatic drive(input int line, input logic v);
    @(posedge i_clock);
    #5;
    case (line)
      0: o_pin = v;
      1: o_cmp0 = v;
      default: o_cmp1 = v;
    endcase
  endtask
endmodule
`default_nettype wire

/* testbench/test_basic_timer.sv */
`default_nettype none
module test_basic_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic            i_clock = 1'b0;
  logic            i_rst = 1'b1;
  logic            i_write = 1'b0;
  logic            i_read = 1'b0;
  logic [7:0]      i_addr = 8'h00;
  logic [7:0]      i_wdata = 8'h00;
  wire logic       pin, cmp0, cmp1, fosc, sosc, xosc, o_pwm, o_count_irq, o_capture_irq;
  wire logic [7:0] o_rdata;
  logic [15:0]     x, y, z;
  logic [7:0]      b;
  int              bad_count = 0, check_count = 0, cyc = 0, t;
  basic_timer uut (.i_clock, .i_rst, .i_addr, .i_wdata, .i_write, .i_read, .i_timer_input_pin(pin),
    .i_comparator0(cmp0), .i_comparator1(cmp1), .i_fast_osc_div2(fosc), .i_slow_osc_div2(sosc),
    .i_crystal_div2(xosc), .o_rdata, .o_pwm, .o_count_irq, .o_capture_irq);
  far_side far (.i_clock, .o_pin(pin), .o_cmp0(cmp0), .o_cmp1(cmp1), .o_fast(fosc), .o_slow(sosc),
    .o_xtal(xosc));
  initial forever #25 i_clock = ~i_clock;
  always @(posedge i_clock) cyc <= cyc + 1;
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #2_000_000;
    bad_count++;
    final_report();
  end
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
    #5;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    idle(1);
    {i_write, i_addr, i_wdata} = {1'b1, a, d};
    idle(1);
    i_write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    idle(1);
    {i_read, i_addr} = {1'b1, a};
    idle(1);
    i_read = 1'b0;
    d = o_rdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    rd(a, b);
    check_val({8'h00, b}, {8'h00, e});
  endtask
  // one line change, then read the captured pair
  task automatic step(input int line, input logic v, output logic [15:0] q);
    far.drive(line, v);
    idle(3);
    rd(8'hC6, q[7:0]);
    rd(8'hC7, q[15:8]);
  endtask
  task automatic wait_irq;
    for (int k = 0; k < 300 && o_count_irq !== 1'b1; k++) idle(1);
    check_val({15'h0, o_count_irq}, 16'h1);
  endtask
  // bytes holds duty, period, initial count
  task automatic setup(input logic [47:0] bytes, input logic [7:0] hi, input logic [7:0] lo);
    wr(8'hC0, 8'h00);
    wr(8'hC1, 8'hF0);
    for (int k = 0; k < 6; k++) wr(8'hC2 + 8'(k), bytes[8*k +: 8]);
    wr(8'hC1, hi);
    wr(8'hC0, lo);
  endtask
  function automatic logic [7:0] pat(input int k);
    return k == 8 ? 8'h00 : k == 0 ? 8'hFC : 8'(8'h21 * k + 8'h1E);
  endfunction
  task automatic reset_vals;
    for (int k = 0; k < 9; k++) rdchk(8'hC0 + 8'(k), (k == 4 || k == 5) ? 8'hFF : 8'h00);
  endtask
  initial begin
    idle(4);
    i_rst = 1'b0;
    reset_vals();
    for (int k = 0; k < 9; k++) wr(8'hC0 + 8'(k), k == 8 ? 8'hA5 : pat(k));
    for (int k = 0; k < 9; k++) rdchk(8'hC0 + 8'(k), pat(k));
    i_rst = 1'b1;
    idle(4);
    i_rst = 1'b0;
    reset_vals();
    for (int p = 0; p < 3; p++) begin
      setup({16'h0, 16'h7, 16'h0}, 8'h20, {3'(p), 3'h5, 2'b01});
      wait_irq();
      t = cyc;
      wr(8'hC1, 8'hA0);
      idle(1);
      check_val({15'h0, o_count_irq}, 16'h0);
      wait_irq();
      check_val(16'(cyc - t), 16'(8 << p));
      rdchk(8'hC1, 8'hA0);
    end
    for (int s = 0; s < 5; s++) begin
      setup({16'h0, 16'h1, 16'h0}, 8'h20, {3'h0, 3'(s), 2'b01});
      if (s < 2) begin
        idle(10);
        check_val({15'h0, o_count_irq}, 16'h0);
        for (int j = 0; j < 4; j++) far.drive(0, j % 2 == 0);
      end
      wait_irq();
    end
    for (int e = 0; e < 4; e++) begin
      setup({16'h0, 16'hFFFF, 16'h0100}, 8'h10 | 8'(e), 8'h17);
      step(0, 1'b1, x);
      step(0, 1'b0, y);
      step(0, 1'b1, z);
      if (e == 0) check_val(z - x, 16'd16);
      if (e == 0) check_val(y, x);
      if (e == 1) check_val(x, 16'h0);
      if (e == 1) check_val(z, y);
      if (e > 1) check_val(y - x, 16'd8);
      if (e > 1) check_val(z - y, 16'd8);
      rdchk(8'hC1, 8'h50 | 8'(e));
      check_val({15'h0, o_capture_irq}, 16'h1);
      far.drive(0, 1'b0);
    end
    setup({16'h0, 16'hFFFF, 16'h0100}, 8'h19, 8'h17);
    step(0, 1'b1, x);
    step(1, 1'b1, y);
    step(2, 1'b1, z);
    check_val(x, 16'h0);
    check_val({15'h0, y != 16'h0}, 16'h1);
    check_val(z, y);
    setup({16'h0, 16'hFFFF, 16'h0100}, 8'h1D, 8'h17);
    step(2, 1'b0, x);
    step(2, 1'b1, y);
    check_val(x, 16'h0);
    check_val({15'h0, y != 16'h0}, 16'h1);
    setup({16'h3, 16'h9, 16'h0}, 8'h00, 8'h16);
    idle(5);
    x = 16'h0;
    repeat (40) begin
      idle(1);
      x = x + {15'h0, o_pwm};
    end
    check_val(x, 16'd12);
    wr(8'hC0, 8'h14);
    idle(3);
    check_val({15'h0, o_pwm}, 16'h0);
    final_report();
  end
endmodule
`default_nettype wire
